/* File: common/dcf_pkg.sv */
// Types shared by the status-flag FIFO modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dcf_pkg;

   // Role of the dual-purpose second write enable pin, caught after reset.
   typedef enum logic {
      DCF_PIN_LOAD = 1'b0,
      DCF_PIN_DUAL = 1'b1
   } dcf_pin_mode_t;

   // Offset register selected by the next load or offset read.
   typedef enum logic [1:0] {
      DCF_SEL_EMPTY_LO = 2'b00,
      DCF_SEL_EMPTY_HI = 2'b01,
      DCF_SEL_FULL_LO  = 2'b10,
      DCF_SEL_FULL_HI  = 2'b11
   } dcf_ofs_sel_t;

endpackage

/* File: common/dcf_regs.svh */
// Constants of the nine-bit status-flag FIFO: depth, widths, reset values.
// Included by the design top and by the verification files; holds definitions only.
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

`define DCF_DATA_W        9
`define DCF_DEPTH         64
`define DCF_CNT_W         7
`define DCF_OFS_W         16
`define DCF_THR_W         17
`define DCF_DEF_EMPTY_OFS 16'h0007
`define DCF_DEF_FULL_OFS  16'h0007
`define DCF_DATA_RST      9'h000

`endif

/* File: rtl/dcf_store.sv */
// Storage FIFO with valid and ready on both sides and a registered word count.
// Assumes one clock and an asynchronous active-low reset; DEPTH is a power of two.
`timescale 1ns/1ps
module dcf_store #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 64
) (
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   input  wire logic                         in_valid_i,
   output logic                              in_ready_o,
   input  wire logic [WIDTH-1:0]             in_data_i,
   output logic                              out_valid_o,
   input  wire logic                         out_ready_i,
   output logic [WIDTH-1:0]                  out_data_o,
   output logic [$clog2(DEPTH+1)-1:0]        count_o
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH+1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
   localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [PTR_W-1:0] nxt_wr_ptr;
   logic [PTR_W-1:0] nxt_rd_ptr;
   logic [CNT_W-1:0] nxt_cnt;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_ff != FULL_CNT);
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o  = mem[rd_ptr_ff];
   assign count_o     = cnt_ff;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_ready_i & out_valid_o;

   always_comb begin
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_cnt    = cnt_ff;
      if (push) begin
         nxt_wr_ptr = wr_ptr_ff + PTR_ONE;
      end
      if (pop) begin
         nxt_rd_ptr = rd_ptr_ff + PTR_ONE;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + CNT_ONE;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - CNT_ONE;
      end
   end

   // Both pointers return to the first location under reset.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         cnt_ff    <= nxt_cnt;
      end
   end

   // The array carries no reset so it maps onto plain memory.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data_i;
      end
   end

endmodule

/* File: rtl/dcf_top.sv */
// Nine-bit FIFO with full, empty and programmable almost flags and offset loading.
// Assumes write and read sides share mclk_i and all inputs are synchronous to it.
//
// Function
// - Full flag low and writes blocked when the count reaches the depth.
// - Full flag changes only on write-clock rising edges.
// - Empty flag low and reads blocked when the count is zero.
// - Almost-full flag low once the count reaches depth minus the full offset.
// - Full offset defaults to seven when nothing was loaded.
// - Almost-full flag changes only on write-clock rising edges.
// - Almost-empty flag low while count is at most the empty offset.
// - Empty offset defaults to seven when nothing was loaded.
// - Almost-empty flag changes only on read-clock rising edges.
// - Flags follow the word count in five count bands.
// - Second write pin level at reset picks second enable or load enable.
// - After reset data reads low when enabled, undriven when disabled.
// - Logic works with both clocks toggling through reset.
// - Full flag may lag one write edge after a close read edge.
// - Empty flag may lag one read edge after a close write edge.
// - Almost flags may lag one edge of their own clock.
// - First word after empty appears one or two read periods later.
// - In dual-enable mode either write enable inactive blocks a write.
// - Depth expansion holds the pin high at reset; offsets stay default.
// - Reset returns both pointers to the first location.
// - Load mode writes offset bytes in a four-step wrapping sequence.
// - Reads ignored while empty, writes ignored while full.
// - Output enable high releases the nine-bit data bus.
`timescale 1ns/1ps
`include "dcf_regs.svh"
module dcf_top (
   input  wire logic                    mclk_i,
   input  wire logic                    arst_n_i,
   input  wire logic [`DCF_DATA_W-1:0]  data_in_i,
   input  wire logic                    write_enable_primary_n_i,
   input  wire logic                    write_enable_second_or_load_i,
   input  wire logic                    read_enable_primary_n_i,
   input  wire logic                    read_enable_second_n_i,
   input  wire logic                    output_enable_n_i,
   output logic [`DCF_DATA_W-1:0]       data_out_o,
   output logic                         data_out_oe_o,
   output logic                         full_flag_n_o,
   output logic                         almost_full_flag_n_o,
   output logic                         empty_flag_n_o,
   output logic                         almost_empty_flag_n_o
);

   localparam logic [`DCF_CNT_W-1:0] CNT_FULL = `DCF_CNT_W'(`DCF_DEPTH);
   localparam logic [`DCF_CNT_W-1:0] CNT_ONE  = `DCF_CNT_W'(1);
   localparam logic [`DCF_THR_W-1:0] THR_FULL = `DCF_THR_W'(`DCF_DEPTH);

   // Low while the count plus the full offset reaches the depth.
   function automatic logic almost_full_n(input logic [`DCF_CNT_W-1:0] cnt,
                                          input logic [`DCF_OFS_W-1:0] ofs);
      logic [`DCF_THR_W-1:0] sum;
      sum = `DCF_THR_W'(cnt) + `DCF_THR_W'(ofs);
      return (sum >= THR_FULL) ? 1'b0 : 1'b1;
   endfunction

   // Low while the count does not exceed the empty offset.
   function automatic logic almost_empty_n(input logic [`DCF_CNT_W-1:0] cnt,
                                           input logic [`DCF_OFS_W-1:0] ofs);
      return (`DCF_OFS_W'(cnt) <= ofs) ? 1'b0 : 1'b1;
   endfunction

   // Byte of an offset register as it appears on the nine-bit output.
   function automatic logic [`DCF_DATA_W-1:0] ofs_byte(input logic [7:0] b);
      return {1'b0, b};
   endfunction

   logic                     cfg_done_ff;
   dcf_pkg::dcf_pin_mode_t   mode_ff;
   logic                     nxt_cfg_done;
   dcf_pkg::dcf_pin_mode_t   nxt_mode;

   logic [`DCF_OFS_W-1:0]    empty_ofs_ff;
   logic [`DCF_OFS_W-1:0]    full_ofs_ff;
   dcf_pkg::dcf_ofs_sel_t    sel_ff;
   logic [`DCF_OFS_W-1:0]    nxt_empty_ofs;
   logic [`DCF_OFS_W-1:0]    nxt_full_ofs;
   dcf_pkg::dcf_ofs_sel_t    nxt_sel;

   logic [`DCF_DATA_W-1:0]   data_ff;
   logic                     oe_ff;
   logic                     full_n_ff;
   logic                     afull_n_ff;
   logic                     empty_n_ff;
   logic                     aempty_n_ff;
   logic [`DCF_DATA_W-1:0]   nxt_data;
   logic                     nxt_oe;
   logic                     nxt_full_n;
   logic                     nxt_afull_n;
   logic                     nxt_empty_n;
   logic                     nxt_aempty_n;

   logic                     pin_high;
   logic                     wr_req;
   logic                     rd_req;
   logic                     ofs_load;
   logic                     ofs_read;
   logic                     in_ready;
   logic                     out_valid;
   logic                     push;
   logic                     pop;
   logic [`DCF_DATA_W-1:0]   head_data;
   logic [`DCF_CNT_W-1:0]    count;
   logic [`DCF_CNT_W-1:0]    cnt_nxt;

   assign pin_high = write_enable_second_or_load_i;
   // A write needs the primary enable low and the second pin high in either mode.
   assign wr_req   = cfg_done_ff & ~write_enable_primary_n_i & pin_high;
   assign rd_req   = cfg_done_ff & ~read_enable_primary_n_i & ~read_enable_second_n_i;
   assign ofs_load = cfg_done_ff & (mode_ff == dcf_pkg::DCF_PIN_LOAD)
                     & ~pin_high & ~write_enable_primary_n_i;
   assign ofs_read = rd_req & (mode_ff == dcf_pkg::DCF_PIN_LOAD) & ~pin_high;
   assign push     = wr_req & in_ready;
   assign pop      = rd_req & ~ofs_read & out_valid;

   dcf_store #(
      .WIDTH (`DCF_DATA_W),
      .DEPTH (`DCF_DEPTH)
   ) u_store (
      .clk_i       (mclk_i),
      .rst_n_i     (arst_n_i),
      .in_valid_i  (wr_req),
      .in_ready_o  (in_ready),
      .in_data_i   (data_in_i),
      .out_valid_o (out_valid),
      .out_ready_i (rd_req & ~ofs_read),
      .out_data_o  (head_data),
      .count_o     (count)
   );

   // The pin role is caught on the first edge after release, since an
   // asynchronous reset may only load constants; no transfer is taken before.
   always_comb begin
      nxt_cfg_done = 1'b1;
      nxt_mode     = mode_ff;
      if (!cfg_done_ff) begin
         nxt_mode = pin_high ? dcf_pkg::DCF_PIN_DUAL : dcf_pkg::DCF_PIN_LOAD;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_done_ff <= 1'b0;
         mode_ff     <= dcf_pkg::DCF_PIN_LOAD;
      end else begin
         cfg_done_ff <= nxt_cfg_done;
         mode_ff     <= nxt_mode;
      end
   end

   // One selector serves both loading and reading of the offsets, so a
   // load and an offset read in the same cycle advance it only once between them.
   always_comb begin
      nxt_empty_ofs = empty_ofs_ff;
      nxt_full_ofs  = full_ofs_ff;
      nxt_sel       = sel_ff;
      if (ofs_load || ofs_read) begin
         case (sel_ff)
            dcf_pkg::DCF_SEL_EMPTY_LO: begin
               nxt_sel = dcf_pkg::DCF_SEL_EMPTY_HI;
            end
            dcf_pkg::DCF_SEL_EMPTY_HI: begin
               nxt_sel = dcf_pkg::DCF_SEL_FULL_LO;
            end
            dcf_pkg::DCF_SEL_FULL_LO: begin
               nxt_sel = dcf_pkg::DCF_SEL_FULL_HI;
            end
            dcf_pkg::DCF_SEL_FULL_HI: begin
               nxt_sel = dcf_pkg::DCF_SEL_EMPTY_LO;
            end
            default: begin
               nxt_sel = dcf_pkg::DCF_SEL_EMPTY_LO;
            end
         endcase
      end
      if (ofs_load) begin
         case (sel_ff)
            dcf_pkg::DCF_SEL_EMPTY_LO: begin
               nxt_empty_ofs = {empty_ofs_ff[15:8], data_in_i[7:0]};
            end
            dcf_pkg::DCF_SEL_EMPTY_HI: begin
               nxt_empty_ofs = {data_in_i[7:0], empty_ofs_ff[7:0]};
            end
            dcf_pkg::DCF_SEL_FULL_LO: begin
               nxt_full_ofs = {full_ofs_ff[15:8], data_in_i[7:0]};
            end
            dcf_pkg::DCF_SEL_FULL_HI: begin
               nxt_full_ofs = {data_in_i[7:0], full_ofs_ff[7:0]};
            end
            default: begin
               nxt_full_ofs = full_ofs_ff;
            end
         endcase
      end
   end

   // Dual-enable mode can never load, so its offsets stay at the defaults.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         empty_ofs_ff <= `DCF_DEF_EMPTY_OFS;
         full_ofs_ff  <= `DCF_DEF_FULL_OFS;
         sel_ff       <= dcf_pkg::DCF_SEL_EMPTY_LO;
      end else begin
         empty_ofs_ff <= nxt_empty_ofs;
         full_ofs_ff  <= nxt_full_ofs;
         sel_ff       <= nxt_sel;
      end
   end

   // Flags come from the count after this edge, so they never lag a
   // transfer; with one clock the permitted extra edge of delay is unused.
   always_comb begin
      cnt_nxt = count;
      if (push && !pop) begin
         cnt_nxt = count + CNT_ONE;
      end else if (pop && !push) begin
         cnt_nxt = count - CNT_ONE;
      end
      nxt_full_n   = (cnt_nxt == CNT_FULL) ? 1'b0 : 1'b1;
      nxt_afull_n  = almost_full_n(cnt_nxt, full_ofs_ff);
      nxt_empty_n  = (cnt_nxt == '0) ? 1'b0 : 1'b1;
      nxt_aempty_n = almost_empty_n(cnt_nxt, empty_ofs_ff);
      nxt_oe       = ~output_enable_n_i;
      nxt_data     = data_ff;
      if (pop) begin
         nxt_data = head_data;
      end else if (ofs_read) begin
         case (sel_ff)
            dcf_pkg::DCF_SEL_EMPTY_LO: begin
               nxt_data = ofs_byte(empty_ofs_ff[7:0]);
            end
            dcf_pkg::DCF_SEL_EMPTY_HI: begin
               nxt_data = ofs_byte(empty_ofs_ff[15:8]);
            end
            dcf_pkg::DCF_SEL_FULL_LO: begin
               nxt_data = ofs_byte(full_ofs_ff[7:0]);
            end
            dcf_pkg::DCF_SEL_FULL_HI: begin
               nxt_data = ofs_byte(full_ofs_ff[15:8]);
            end
            default: begin
               nxt_data = data_ff;
            end
         endcase
      end
   end

   // All flags are registered from the shared clock, which here stands for
   // both the write clock and the read clock.
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         full_n_ff   <= 1'b1;
         afull_n_ff  <= 1'b1;
         empty_n_ff  <= 1'b0;
         aempty_n_ff <= 1'b0;
         data_ff     <= `DCF_DATA_RST;
         oe_ff       <= 1'b0;
      end else begin
         full_n_ff   <= nxt_full_n;
         afull_n_ff  <= nxt_afull_n;
         empty_n_ff  <= nxt_empty_n;
         aempty_n_ff <= nxt_aempty_n;
         data_ff     <= nxt_data;
         oe_ff       <= nxt_oe;
      end
   end

   assign data_out_o            = data_ff;
   assign data_out_oe_o         = oe_ff;
   assign full_flag_n_o         = full_n_ff;
   assign almost_full_flag_n_o  = afull_n_ff;
   assign empty_flag_n_o        = empty_n_ff;
   assign almost_empty_flag_n_o = aempty_n_ff;

endmodule

/* File: verif/dcf_ctrl_model.sv */
// Controller model for both sides of the FIFO: enables, pin role and write data.
// Assumes calls from one bench process; changes land 1 ns after a rising clock edge.
`timescale 1ns/1ps
`include "dcf_regs.svh"
module dcf_ctrl_model (
   input  wire logic                  clk_i,
   output logic                       wr_n_o,
   output logic                       pin_o,
   output logic                       rd1_n_o,
   output logic                       rd2_n_o,
   output logic [`DCF_DATA_W-1:0]     data_o
);
   initial begin
      wr_n_o = 1'h1;
      pin_o = 1'h1;
      rd1_n_o = 1'h1;
      rd2_n_o = 1'h1;
      data_o = 9'h000;
   end
   task automatic drive(input logic wn, input logic p, input logic r1, input logic r2,
                        input logic [`DCF_DATA_W-1:0] d);
      @(posedge clk_i);
      #1;
      wr_n_o = wn;
      pin_o = p;
      rd1_n_o = r1;
      rd2_n_o = r2;
      data_o = d;
   endtask
   // Low at reset asks for offset loading; high keeps default offsets for depth expansion.
   task automatic hold_role(input logic p);
      pin_o = p;
   endtask
endmodule

/* File: verif/dcf_top_monitor.sv */
// Port-level checks of the status-flag FIFO top, attached by a bind in the bench.
// Assumes one clock domain and the top's asynchronous active-low reset.
`timescale 1ns/1ps
`include "dcf_regs.svh"
module dcf_top_monitor (
   input wire logic                   mclk_i,
   input wire logic                   arst_n_i,
   input wire logic [`DCF_DATA_W-1:0] data_in_i,
   input wire logic                   write_enable_primary_n_i,
   input wire logic                   write_enable_second_or_load_i,
   input wire logic                   read_enable_primary_n_i,
   input wire logic                   read_enable_second_n_i,
   input wire logic                   output_enable_n_i,
   input wire logic [`DCF_DATA_W-1:0] data_out_o,
   input wire logic                   data_out_oe_o,
   input wire logic                   full_flag_n_o,
   input wire logic                   almost_full_flag_n_o,
   input wire logic                   empty_flag_n_o,
   input wire logic                   almost_empty_flag_n_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);
   property p_full_holds;
      !full_flag_n_o && read_enable_primary_n_i |=> !full_flag_n_o;
   endproperty
   a_full_holds: assert property (p_full_holds) else $error("full left without read");
   property p_empty_holds;
      !empty_flag_n_o && (write_enable_primary_n_i || !write_enable_second_or_load_i)
         |=> !empty_flag_n_o;
   endproperty
   a_empty_holds: assert property (p_empty_holds) else $error("empty left without write");
   property p_full_afull;
      !full_flag_n_o |-> !almost_full_flag_n_o;
   endproperty
   a_full_afull: assert property (p_full_afull) else $error("full without almost full");
   property p_empty_aempty;
      !empty_flag_n_o |-> !almost_empty_flag_n_o && full_flag_n_o;
   endproperty
   a_empty_aempty: assert property (p_empty_aempty) else $error("empty band wrong");
   property p_oe_off;
      output_enable_n_i |=> !data_out_oe_o;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("bus not released");
   property p_oe_on;
      !output_enable_n_i |=> data_out_oe_o;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("bus not driven");
   property p_empty_data;
      !empty_flag_n_o && write_enable_primary_n_i && write_enable_second_or_load_i
         |=> $stable(data_out_o);
   endproperty
   a_empty_data: assert property (p_empty_data) else $error("read taken while empty");
   property p_full_rise;
      $rose(full_flag_n_o) |-> $past(!read_enable_primary_n_i && !read_enable_second_n_i);
   endproperty
   a_full_rise: assert property (p_full_rise) else $error("full cleared without read");
endmodule

/* File: verif/tb_dual_clock_fifo_status_flags.sv */
// Self-checking bench for the status-flag FIFO top, driven through the controller model.
// Assumes the design, the model and the monitor are compiled before this file.
`timescale 1ns/1ps
`include "dcf_regs.svh"
`define CHK(nm, ex, got) \
   begin \
      n_compared++; \
      if ((got) !== (ex)) begin \
         mismatches++; \
         $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
      end \
   end
module tb_dual_clock_fifo_status_flags;
   logic                  mclk_i = 1'h0;
   logic                  arst_n_i = 1'h0;
   logic                  oe_n = 1'h0;
   logic                  wr_n, pin, rd1_n, rd2_n, oe;
   logic                  full_n, afull_n, empty_n, aempty_n;
   logic [`DCF_DATA_W-1:0] din, dout;
   int                    mismatches = 0;
   int                    n_compared = 0;
   always #2 mclk_i = ~mclk_i;
   dcf_ctrl_model u_ctrl (.clk_i(mclk_i), .wr_n_o(wr_n), .pin_o(pin), .rd1_n_o(rd1_n),
      .rd2_n_o(rd2_n), .data_o(din));
   dcf_top u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .data_in_i(din),
      .write_enable_primary_n_i(wr_n), .write_enable_second_or_load_i(pin),
      .read_enable_primary_n_i(rd1_n), .read_enable_second_n_i(rd2_n),
      .output_enable_n_i(oe_n), .data_out_o(dout), .data_out_oe_o(oe),
      .full_flag_n_o(full_n), .almost_full_flag_n_o(afull_n), .empty_flag_n_o(empty_n),
      .almost_empty_flag_n_o(aempty_n));
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Each operation is followed by an idle cycle; the data lines show the inverse meanwhile.
   task automatic op(input logic wn, input logic p, input logic r1, input logic r2,
                     input logic [`DCF_DATA_W-1:0] d);
      u_ctrl.drive(wn, p, r1, r2, d);
      u_ctrl.drive(1'h1, 1'h1, 1'h1, 1'h1, ~d);
   endtask
   task automatic chk_flags(input int cnt, input int n, input int m);
      logic [3:0] ex;
      ex = {cnt != `DCF_DEPTH, cnt + m < `DCF_DEPTH, cnt > n, cnt != 0};
      // With one device in the bank its own empty and full flags are the composites.
      `CHK("flags", ex, {full_n, afull_n, aempty_n, empty_n})
   endtask
   task automatic do_reset(input logic p);
      @(posedge mclk_i);
      #1;
      u_ctrl.hold_role(p);
      arst_n_i = 1'h0;
      repeat (4) @(posedge mclk_i);
      #1 arst_n_i = 1'h1;
      @(posedge mclk_i);
      #1 u_ctrl.hold_role(1'h1);
      `CHK("out after reset", 9'h000, dout)
      chk_flags(0, 7, 7);
   endtask
   task automatic t_load;
      do_reset(1'h0);
      op(1'h0, 1'h0, 1'h1, 1'h1, 9'h003);
      op(1'h0, 1'h0, 1'h1, 1'h1, 9'h000);
      op(1'h0, 1'h0, 1'h1, 1'h1, 9'h00a);
      op(1'h0, 1'h0, 1'h1, 1'h1, 9'h000);
      chk_flags(0, 3, 10);
      op(1'h1, 1'h0, 1'h0, 1'h0, 9'h000);
      `CHK("offset readback", 9'h003, dout)
      op(1'h1, 1'h0, 1'h0, 1'h0, 9'h000);
      `CHK("empty ofs hi", 9'h000, dout)
      op(1'h1, 1'h0, 1'h0, 1'h0, 9'h000);
      `CHK("full ofs lo", 9'h00a, dout)
      op(1'h1, 1'h0, 1'h0, 1'h0, 9'h000);
      `CHK("full ofs hi", 9'h000, dout)
      // The selector has wrapped, so this load lands in the empty offset low byte.
      op(1'h0, 1'h0, 1'h1, 1'h1, 9'h005);
      for (int i = 1; i <= 60; i++) begin
         op(1'h0, 1'h1, 1'h1, 1'h1, 9'(i));
         chk_flags(i, 5, 10);
      end
      repeat (4) u_ctrl.drive(1'h0, 1'h1, 1'h1, 1'h1, 9'h0aa);
      op(1'h1, 1'h1, 1'h1, 1'h1, 9'h000);
      chk_flags(64, 5, 10);
   endtask
   task automatic t_fill_drain;
      do_reset(1'h1);
      op(1'h0, 1'h0, 1'h1, 1'h1, 9'h155);
      chk_flags(0, 7, 7);
      for (int i = 1; i <= `DCF_DEPTH; i++) begin
         op(1'h0, 1'h1, 1'h1, 1'h1, 9'(i * 37));
         chk_flags(i, 7, 7);
      end
      op(1'h0, 1'h1, 1'h1, 1'h1, 9'h1ff);
      chk_flags(64, 7, 7);
      op(1'h1, 1'h1, 1'h0, 1'h1, 9'h000);
      chk_flags(64, 7, 7);
      for (int i = 1; i <= `DCF_DEPTH; i++) begin
         op(1'h1, 1'h1, 1'h0, 1'h0, 9'h000);
         `CHK("read word", 9'(i * 37), dout)
         chk_flags(64 - i, 7, 7);
      end
      op(1'h1, 1'h1, 1'h0, 1'h0, 9'h000);
      `CHK("read when empty", 9'h140, dout)
      // A read on the edge right after the first write must already return it.
      u_ctrl.drive(1'h0, 1'h1, 1'h1, 1'h1, 9'h0c3);
      u_ctrl.drive(1'h1, 1'h1, 1'h0, 1'h0, 9'h000);
      op(1'h1, 1'h1, 1'h1, 1'h1, 9'h000);
      `CHK("first word", 9'h0c3, dout)
      chk_flags(0, 7, 7);
   endtask
   task automatic t_oe;
      @(posedge mclk_i);
      #1 oe_n = 1'h1;
      @(posedge mclk_i);
      #1;
      `CHK("bus release", 1'h0, oe)
      oe_n = 1'h0;
      @(posedge mclk_i);
      #1;
      `CHK("bus drive", 1'h1, oe)
   endtask
   initial begin
      t_load;
      t_fill_drain;
      t_oe;
      wrap_up;
   end
   initial begin
      #40000;
      mismatches++;
      wrap_up;
   end
endmodule
bind dcf_top dcf_top_monitor u_mon (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
   .data_in_i(data_in_i), .write_enable_primary_n_i(write_enable_primary_n_i),
   .write_enable_second_or_load_i(write_enable_second_or_load_i),
   .read_enable_primary_n_i(read_enable_primary_n_i),
   .read_enable_second_n_i(read_enable_second_n_i), .output_enable_n_i(output_enable_n_i),
   .data_out_o(data_out_o), .data_out_oe_o(data_out_oe_o), .full_flag_n_o(full_flag_n_o),
   .almost_full_flag_n_o(almost_full_flag_n_o), .empty_flag_n_o(empty_flag_n_o),
   .almost_empty_flag_n_o(almost_empty_flag_n_o));
